// ### core/clk_ctrl_pkg.sv
// constants and carrier types for the clock chip system control register bank
package clk_ctrl_pkg;

    // register addresses on the serial port
    localparam int ADDR_W = 13;
    localparam logic [12:0] ADDR_RESET_MODE = 13'h0000;
    localparam logic [12:0] ADDR_POWER_DOWN = 13'h0002;
    localparam logic [12:0] ADDR_DEV_TYPE = 13'h0003;
    localparam logic [12:0] ADDR_PROD_HI = 13'h0004;
    localparam logic [12:0] ADDR_PROD_LO = 13'h0005;
    localparam logic [12:0] ADDR_SI_REV = 13'h0006;
    localparam logic [12:0] ADDR_MAKER_HI = 13'h000c;
    localparam logic [12:0] ADDR_MAKER_LO = 13'h000d;
    localparam logic [12:0] ADDR_FIX_A = 13'h0171;
    localparam logic [12:0] ADDR_FIX_B = 13'h0172;
    localparam logic [12:0] ADDR_LOOP2_PD = 13'h0173;
    localparam logic [12:0] ADDR_OPT1 = 13'h017c;
    localparam logic [12:0] ADDR_OPT2 = 13'h017d;
    localparam logic [12:0] ADDR_LOCK1 = 13'h0182;
    localparam logic [12:0] ADDR_LOCK2 = 13'h0183;
    localparam logic [12:0] ADDR_SEL_DAC = 13'h0184;
    localparam logic [12:0] ADDR_DAC_LO = 13'h0185;
    localparam logic [12:0] ADDR_HOLDOVER = 13'h0188;
    localparam logic [12:0] ADDR_CFG_LOCK_HI = 13'h1ffd;
    localparam logic [12:0] ADDR_CFG_LOCK_MID = 13'h1ffe;
    localparam logic [12:0] ADDR_CFG_LOCK_LO = 13'h1fff;

    // field positions
    localparam int SOFT_RESET_BIT = 7;
    localparam int THREE_WIRE_DIS_BIT = 4;
    localparam int POWER_DOWN_BIT = 0;
    localparam int LOOP2_PRE_PD_BIT = 6;
    localparam int LOOP2_PD_BIT = 5;
    localparam int LOCK_LOST_BIT = 2;
    localparam int LOCK_LIVE_BIT = 1;
    localparam int LOCK_CLEAR_BIT = 0;
    localparam int HOLDOVER_BIT = 4;

    // values after reset
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] FIX_A_RST = 8'haa;
    localparam logic [7:0] FIX_B_RST = 8'h02;

    // serial frame layout: read flag, two length bits, 13 address bits, 8 data bits
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] HEADER_LAST = 5'h0f;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // repeated output field indices
    localparam int EVEN_IDX_MAX = 12;
    localparam int ODD_IDX_MAX = EVEN_IDX_MAX + 1;

    // serial pins as they arrive
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdio;
    } spi_in_t;

    // live status of the analog side
    typedef struct packed {
        logic loop1_lock;
        logic loop2_lock;
        logic holdover;
        logic [2:0] input_sel;
        logic [1:0] input_los;
        logic [9:0] dac;
    } status_in_t;

    // control outputs toward the rest of the chip
    typedef struct packed {
        logic soft_reset;
        logic three_wire_disable;
        logic power_down;
        logic loop2_prescaler_off;
        logic loop2_off;
    } ctrl_out_t;

endpackage

// ### core/clock_chip_system_control_regs.sv
// serial-port register bank for system control, identification and loop status
//
// Overview of operation
// - soft reset bit resets bank, clears itself
// - bit four disables three-wire readback
// - four-wire readback only on selected pin
// - register two bit zero powers down
// - register three returns device type code
// - registers four, five hold product code
// - register six returns silicon revision code
// - registers 0x00c, 0x00d hold maker code
// - fields start at power-on defaults
// - odd output index equals even plus one
`timescale 1ns/100ps
module clock_chip_system_control_regs #(
    parameter logic [7:0] DEVICE_TYPE_CODE = 8'h11, // arbitrary value
    parameter logic [15:0] PRODUCT_CODE = 16'h2233, // arbitrary value
    parameter logic [7:0] SILICON_REV_CODE = 8'h01, // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'h4455, // arbitrary value
    parameter logic [7:0] OPT1_RST = 8'h00,
    parameter logic [7:0] OPT2_RST = 8'h00,
    parameter logic [23:0] CFG_LOCK_RST = 24'h000000
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire clk_ctrl_pkg::spi_in_t spi_i,
    input wire logic readback_pin_sel_i,
    input wire clk_ctrl_pkg::status_in_t status_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    output logic readback_pin_o,
    output clk_ctrl_pkg::ctrl_out_t ctrl_o,
    output logic [15:0] opt_word_o,
    output logic [23:0] cfg_lock_o
);
    import clk_ctrl_pkg::*;

    // elaboration check on the repeated index layout
    if (ODD_IDX_MAX != EVEN_IDX_MAX + 1) begin : g_bad_index
        $error("odd output index must be even index plus one");
    end

    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pin synchroniser, two stages, then a history stage for edges
    spi_in_t pin_s1_q;
    spi_in_t pin_s2_q;
    logic sclk_prev_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
            pin_s2_q <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= spi_i;
            pin_s2_q <= pin_s1_q;
            sclk_prev_q <= pin_s2_q.sclk;
        end
    end

    // edge and frame decode
    wire selected_w = !pin_s2_q.cs_n;
    wire sclk_rise_w = selected_w && pin_s2_q.sclk && !sclk_prev_q;
    wire sclk_fall_w = selected_w && !pin_s2_q.sclk && sclk_prev_q;

    logic [4:0] bit_cnt_q;
    logic [22:0] shift_q;
    logic [12:0] frame_addr_q;
    logic is_read_q;
    logic load_pend_q;
    logic rd_phase_q;
    logic [7:0] rd_shift_q;
    logic [7:0] rd_data_w;

    // serial receive: shift on rising clock, latch header after bit 15
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 23'h000000;
            frame_addr_q <= 13'h0000;
            is_read_q <= 1'b0;
        end else if (!selected_w) begin
            bit_cnt_q <= 5'h00;
            is_read_q <= 1'b0;
        end else if (sclk_rise_w) begin
            shift_q <= {shift_q[21:0], pin_s2_q.sdio};
            if (bit_cnt_q < FRAME_BITS) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (bit_cnt_q == HEADER_LAST) begin
                frame_addr_q <= {shift_q[11:0], pin_s2_q.sdio};
                is_read_q <= shift_q[14];
            end
        end
    end

    // serial transmit: load on the falling edge after the header, shift msb first
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_q <= 1'b0;
            rd_phase_q <= 1'b0;
            rd_shift_q <= BYTE_ZERO;
        end else if (!selected_w) begin
            load_pend_q <= 1'b0;
            rd_phase_q <= 1'b0;
        end else if (sclk_rise_w && bit_cnt_q == HEADER_LAST) begin
            load_pend_q <= shift_q[14];
        end else if (sclk_fall_w && load_pend_q) begin
            load_pend_q <= 1'b0;
            rd_phase_q <= 1'b1;
            rd_shift_q <= rd_data_w;
        end else if (sclk_fall_w && rd_phase_q) begin
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
            if (bit_cnt_q == FRAME_BITS) begin
                rd_phase_q <= 1'b0;
            end
        end
    end

    // write strobe after the last data bit of a write frame
    logic wr_en_q;
    logic [12:0] wr_addr_q;
    logic [7:0] wr_data_q;
    wire wr_take_w = sclk_rise_w && bit_cnt_q == FRAME_LAST && !is_read_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= 13'h0000;
            wr_data_q <= BYTE_ZERO;
        end else begin
            wr_en_q <= wr_take_w;
            if (wr_take_w) begin
                wr_addr_q <= frame_addr_q;
                wr_data_q <= {shift_q[6:0], pin_s2_q.sdio};
            end
        end
    end

    // address match of the pending write
    function automatic logic wr_hit(input logic en, input logic [12:0] a, input logic [12:0] target);
        wr_hit = en && (a == target);
    endfunction

    // soft reset pulse, one cycle, never stored
    logic soft_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr_hit(wr_en_q, wr_addr_q, ADDR_RESET_MODE) && wr_data_q[SOFT_RESET_BIT];
        end
    end

    // writable control registers, defaults on reset and soft reset
    logic twd_q;
    logic pd_q;
    logic [7:0] fix_a_q;
    logic [7:0] fix_b_q;
    logic pre_pd_q;
    logic loop2_pd_q;
    logic [7:0] opt1_q;
    logic [7:0] opt2_q;
    logic [23:0] cfg_lock_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            twd_q <= 1'b0;
            pd_q <= 1'b0;
            fix_a_q <= FIX_A_RST;
            fix_b_q <= FIX_B_RST;
            pre_pd_q <= 1'b0;
            loop2_pd_q <= 1'b0;
            opt1_q <= OPT1_RST;
            opt2_q <= OPT2_RST;
            cfg_lock_q <= CFG_LOCK_RST;
        end else if (soft_q) begin
            twd_q <= 1'b0;
            pd_q <= 1'b0;
            fix_a_q <= FIX_A_RST;
            fix_b_q <= FIX_B_RST;
            pre_pd_q <= 1'b0;
            loop2_pd_q <= 1'b0;
            opt1_q <= OPT1_RST;
            opt2_q <= OPT2_RST;
            cfg_lock_q <= CFG_LOCK_RST;
        end else begin
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_RESET_MODE)) begin
                twd_q <= wr_data_q[THREE_WIRE_DIS_BIT];
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_POWER_DOWN)) begin
                pd_q <= wr_data_q[POWER_DOWN_BIT];
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_FIX_A)) begin
                fix_a_q <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_FIX_B)) begin
                fix_b_q <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_LOOP2_PD)) begin
                pre_pd_q <= wr_data_q[LOOP2_PRE_PD_BIT];
                loop2_pd_q <= wr_data_q[LOOP2_PD_BIT];
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_OPT1)) begin
                opt1_q <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_OPT2)) begin
                opt2_q <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_CFG_LOCK_HI)) begin
                cfg_lock_q[23:16] <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_CFG_LOCK_MID)) begin
                cfg_lock_q[15:8] <= wr_data_q;
            end
            if (wr_hit(wr_en_q, wr_addr_q, ADDR_CFG_LOCK_LO)) begin
                cfg_lock_q[7:0] <= wr_data_q;
            end
        end
    end

    // sticky lock-lost flags, one per loop; a loss in the clear cycle wins
    logic [1:0] live_w;
    logic [1:0] live_prev_q;
    logic [1:0] lost_q;
    logic [1:0] clear_w;
    assign live_w = {status_i.loop2_lock, status_i.loop1_lock};
    for (genvar i = 0; i < 2; i++) begin : g_loop
        localparam logic [12:0] LOCK_ADDR = (i == 0) ? ADDR_LOCK1 : ADDR_LOCK2;
        assign clear_w[i] = wr_hit(wr_en_q, wr_addr_q, LOCK_ADDR) && wr_data_q[LOCK_CLEAR_BIT];
        always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
                live_prev_q[i] <= 1'b0;
                lost_q[i] <= 1'b0;
            end else begin
                live_prev_q[i] <= live_w[i];
                if (live_prev_q[i] && !live_w[i]) begin
                    lost_q[i] <= 1'b1;
                end else if (clear_w[i] || soft_q) begin
                    lost_q[i] <= 1'b0;
                end
            end
        end
    end

    // read data select; identifier bytes and the select, dac and holdover status bytes have no write path
    function automatic logic [7:0] read_mux(input logic [12:0] a);
        case (a)
            ADDR_RESET_MODE: read_mux = {soft_q, 2'b00, twd_q, 4'h0};
            ADDR_POWER_DOWN: read_mux = {7'h00, pd_q};
            ADDR_DEV_TYPE: read_mux = DEVICE_TYPE_CODE;
            ADDR_PROD_HI: read_mux = PRODUCT_CODE[15:8];
            ADDR_PROD_LO: read_mux = PRODUCT_CODE[7:0];
            ADDR_SI_REV: read_mux = SILICON_REV_CODE;
            ADDR_MAKER_HI: read_mux = MAKER_CODE[15:8];
            ADDR_MAKER_LO: read_mux = MAKER_CODE[7:0];
            ADDR_FIX_A: read_mux = fix_a_q;
            ADDR_FIX_B: read_mux = fix_b_q;
            ADDR_LOOP2_PD: read_mux = {1'b0, pre_pd_q, loop2_pd_q, 5'h00};
            ADDR_OPT1: read_mux = opt1_q;
            ADDR_OPT2: read_mux = opt2_q;
            ADDR_LOCK1: read_mux = {5'h00, lost_q[0], live_w[0], 1'b0};
            ADDR_LOCK2: read_mux = {5'h00, lost_q[1], live_w[1], 1'b0};
            ADDR_SEL_DAC: read_mux = {status_i.dac[9:8], status_i.input_sel, 1'b0, status_i.input_los};
            ADDR_DAC_LO: read_mux = status_i.dac[7:0];
            ADDR_HOLDOVER: read_mux = {3'b000, status_i.holdover, 4'h0};
            ADDR_CFG_LOCK_HI: read_mux = cfg_lock_q[23:16];
            ADDR_CFG_LOCK_MID: read_mux = cfg_lock_q[15:8];
            ADDR_CFG_LOCK_LO: read_mux = cfg_lock_q[7:0];
            default: read_mux = BYTE_ZERO;
        endcase
    endfunction
    assign rd_data_w = read_mux(frame_addr_q);

    // readback routing: sdio in three-wire mode, selected pin in either mode
    assign sdio_o = rd_shift_q[7];
    assign sdio_oe_o = rd_phase_q && selected_w && !twd_q;
    assign readback_pin_o = readback_pin_sel_i && rd_phase_q && rd_shift_q[7];

    // control outputs
    assign ctrl_o.soft_reset = soft_q;
    assign ctrl_o.three_wire_disable = twd_q;
    assign ctrl_o.power_down = pd_q;
    assign ctrl_o.loop2_prescaler_off = pre_pd_q;
    assign ctrl_o.loop2_off = loop2_pd_q;
    assign opt_word_o = {opt1_q, opt2_q};
    assign cfg_lock_o = cfg_lock_q;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence s_soft_write;
        wr_en_q && wr_addr_q == ADDR_RESET_MODE && wr_data_q[SOFT_RESET_BIT];
    endsequence
    sequence s_soft_done;
        soft_q ##1 (!soft_q && !twd_q && !pd_q && fix_a_q == FIX_A_RST && fix_b_q == FIX_B_RST);
    endsequence

    a_soft_reset_clears: assert property (s_soft_write |=> s_soft_done)
        else $error("soft reset did not pulse and restore defaults");

    a_wire_mode_write: assert property (
        wr_en_q && wr_addr_q == ADDR_RESET_MODE && !wr_data_q[SOFT_RESET_BIT]
        |=> twd_q == $past(wr_data_q[THREE_WIRE_DIS_BIT]))
        else $error("three-wire disable not taken from write");

    a_sdio_drive_mode: assert property ($rose(sdio_oe_o) |-> !twd_q && $past(load_pend_q) && $past(sclk_fall_w))
        else $error("sdio driven while three-wire readback disabled");

    a_four_wire_pin: assert property (readback_pin_o |-> readback_pin_sel_i && rd_shift_q[7])
        else $error("readback pin active without selection");

    a_power_down_follow: assert property (
        wr_en_q && wr_addr_q == ADDR_POWER_DOWN
        |=> ctrl_o.power_down == $past(wr_data_q[POWER_DOWN_BIT]))
        else $error("power down does not follow write");

    a_id_readback: assert property (
        load_pend_q && sclk_fall_w && frame_addr_q == ADDR_PROD_HI
        |=> rd_shift_q == PRODUCT_CODE[15:8] && rd_phase_q)
        else $error("product code high byte not loaded for readback");

    a_maker_readback: assert property (
        load_pend_q && sclk_fall_w && frame_addr_q == ADDR_MAKER_LO
        |=> rd_shift_q == MAKER_CODE[7:0])
        else $error("maker code low byte not loaded for readback");

    a_reset_defaults: assert property ($rose(rst_sync_q[1]) |-> !twd_q && !pd_q && !soft_q ##1 !twd_q)
        else $error("control bits not zero after reset");

    a_lost_flag_set: assert property ($fell(live_w[0]) |=> lost_q[0] [*2])
        else $error("lock loss not captured as sticky flag");

    a_lost_flag_hold: assert property (lost_q[1] && !clear_w[1] && !soft_q |=> lost_q[1])
        else $error("lock-lost flag dropped without clear");

    a_ro_write_ignored: assert property (
        wr_en_q && wr_addr_q == ADDR_LOCK1 && !wr_data_q[LOCK_CLEAR_BIT] && lost_q[0] && !soft_q
        |=> lost_q[0])
        else $error("write to status register changed flag");

endmodule // clock_chip_system_control_regs

// ### bench/spi_host_model.sv
// host-side model of the serial configuration port master
`timescale 1ns/100ps
module spi_host_model (
    input wire logic mclk_i,
    input wire logic req_i,
    input wire logic [23:0] frame_i,
    input wire logic [4:0] nbits_i,
    input wire logic four_wire_i,
    input wire logic sdio_i,
    input wire logic rb_pin_i,
    output clk_ctrl_pkg::spi_in_t spi_o,
    output logic [7:0] rdata_o,
    output logic done_o
);
    import clk_ctrl_pkg::*;
    logic rd_q;
    // idle: deselected, serial clock parked low
    initial begin
        spi_o = {1'b1, 1'b0, 1'b0};
        rdata_o = 8'h00;
        done_o = 1'b0;
        rd_q = 1'b0;
    end
    // one frame per request, msb first, each sclk phase four mclk long
    always begin
        @(posedge mclk_i);
        if (req_i && !done_o) begin
            rd_q = frame_i[23];
            spi_o.cs_n <= 1'b0;
            spi_o.sdio <= frame_i[23];
            for (int i = 0; i < 24 && i < int'(nbits_i); i++) begin
                repeat (4) @(posedge mclk_i);
                spi_o.sclk <= 1'b1;
                // read data from sdio or from the chosen output pin
                if (rd_q && i >= 16) rdata_o <= {rdata_o[6:0], four_wire_i ? rb_pin_i : sdio_i};
                repeat (4) @(posedge mclk_i);
                spi_o.sclk <= 1'b0;
                // released for read data: keep changing so a stale bit never looks valid
                if (rd_q && i >= 15) spi_o.sdio <= ~spi_o.sdio;
                else if (i < 23) spi_o.sdio <= frame_i[22-i];
            end
            repeat (4) @(posedge mclk_i);
            spi_o.cs_n <= 1'b1;
            repeat (4) @(posedge mclk_i);
            done_o <= 1'b1;
        end else if (!req_i) begin
            done_o <= 1'b0;
        end
    end
endmodule // spi_host_model

// ### bench/clock_chip_system_control_regs_tb.sv
// self-checking bench for the system control register bank
`timescale 1ns/100ps
module clock_chip_system_control_regs_tb;
    import clk_ctrl_pkg::*;
    localparam logic [7:0] DEV_T = 8'h3c; // arbitrary value
    localparam logic [15:0] PROD = 16'h7e19; // arbitrary value
    localparam logic [7:0] SREV = 8'h0b; // arbitrary value
    localparam logic [15:0] MAKER = 16'h5ac3; // arbitrary value
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic readback_pin_sel_i = 1'b0;
    status_in_t status_i = {1'b1, 1'b1, 1'b1, 3'b101, 2'b10, 10'h2a5};
    spi_in_t host_spi;
    spi_in_t spi_i;
    logic sdio_o, sdio_oe_o, readback_pin_o, done;
    ctrl_out_t ctrl_o;
    logic [15:0] opt_word_o;
    logic [23:0] cfg_lock_o, frame = 24'h000000;
    logic [7:0] rdata;
    logic [4:0] nbits = 5'd24;
    logic req = 1'b0, four_wire = 1'b0, sr_seen = 1'b0, oe_seen = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    always #5 mclk_i = ~mclk_i;
    // sdio wire: device level while it drives, host level otherwise
    assign spi_i = {host_spi.cs_n, host_spi.sclk, sdio_oe_o ? sdio_o : host_spi.sdio};
    clock_chip_system_control_regs #(.DEVICE_TYPE_CODE(DEV_T), .PRODUCT_CODE(PROD),
        .SILICON_REV_CODE(SREV), .MAKER_CODE(MAKER)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .spi_i(spi_i), .readback_pin_sel_i(readback_pin_sel_i), .status_i(status_i), .sdio_o(sdio_o),
        .sdio_oe_o(sdio_oe_o), .readback_pin_o(readback_pin_o), .ctrl_o(ctrl_o), .opt_word_o(opt_word_o),
        .cfg_lock_o(cfg_lock_o));
    spi_host_model i_host (.mclk_i(mclk_i), .req_i(req), .frame_i(frame), .nbits_i(nbits),
        .four_wire_i(four_wire), .sdio_i(spi_i.sdio), .rb_pin_i(readback_pin_o), .spi_o(host_spi),
        .rdata_o(rdata), .done_o(done));
    // remember soft reset pulses and sdio drive
    always @(posedge mclk_i) begin
        if (ctrl_o.soft_reset === 1'b1) sr_seen <= 1'b1;
        if (sdio_oe_o === 1'b1) oe_seen <= 1'b1;
    end
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge mclk_i);
        frame <= {rd, 2'b00, a, d};
        req <= 1'b1;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge mclk_i);
            k++;
        end
        chk("frame done", 24'h1, {23'h0, done});
        req <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        xfer(1'b0, a, d);
    endtask
    task automatic rd_chk(input string what, input logic [12:0] a, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b1, a, 8'h00);
        chk(what, {16'h0, e & m}, {16'h0, rdata & m});
    endtask
    task automatic set_lock(input int n, input logic v);
        @(posedge mclk_i);
        if (n == 0) status_i.loop1_lock <= v;
        else status_i.loop2_lock <= v;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic t_ids();
        rd_chk("device type", ADDR_DEV_TYPE, 8'hff, DEV_T);
        rd_chk("product high", ADDR_PROD_HI, 8'hff, PROD[15:8]);
        rd_chk("product low", ADDR_PROD_LO, 8'hff, PROD[7:0]);
        rd_chk("silicon rev", ADDR_SI_REV, 8'hff, SREV);
        rd_chk("maker high", ADDR_MAKER_HI, 8'hff, MAKER[15:8]);
        rd_chk("maker low", ADDR_MAKER_LO, 8'hff, MAKER[7:0]);
        rd_chk("select dac", ADDR_SEL_DAC, 8'hfb, 8'haa);
        rd_chk("dac low", ADDR_DAC_LO, 8'hff, 8'ha5);
        rd_chk("holdover", ADDR_HOLDOVER, 8'hf0, 8'h10);
    endtask
    task automatic t_defaults();
        chk("ctrl after reset", 24'h0, {19'h0, ctrl_o});
        chk("opt after reset", 24'h0, {8'h0, opt_word_o});
        chk("lock word after reset", 24'h0, cfg_lock_o);
        rd_chk("reset mode", ADDR_RESET_MODE, 8'hff, 8'h00);
        rd_chk("power down", ADDR_POWER_DOWN, 8'hff, 8'h00);
        rd_chk("pattern a", ADDR_FIX_A, 8'hff, 8'haa);
        rd_chk("pattern b", ADDR_FIX_B, 8'hff, 8'h02);
        rd_chk("loop2 power", ADDR_LOOP2_PD, 8'hff, 8'h00);
        rd_chk("lock one", ADDR_LOCK1, 8'hff, 8'h02);
        rd_chk("lock two", ADDR_LOCK2, 8'hff, 8'h02);
        rd_chk("unmapped", 13'h0001, 8'hff, 8'h00);
        t_ids();
        $display("t_defaults done");
    endtask
    task automatic t_readonly();
        logic [12:0] ro [9];
        ro = '{ADDR_DEV_TYPE, ADDR_PROD_HI, ADDR_PROD_LO, ADDR_SI_REV, ADDR_MAKER_HI, ADDR_MAKER_LO,
               ADDR_SEL_DAC, ADDR_DAC_LO, ADDR_HOLDOVER};
        foreach (ro[i]) wr(ro[i], 8'hff);
        t_ids();
        $display("t_readonly done");
    endtask
    task automatic t_writes();
        wr(ADDR_POWER_DOWN, 8'h01);
        chk("power down out", 24'h1, {23'h0, ctrl_o.power_down});
        rd_chk("power down rd", ADDR_POWER_DOWN, 8'hff, 8'h01);
        nbits <= 5'd16;
        wr(ADDR_POWER_DOWN, 8'h00);
        nbits <= 5'd24;
        chk("short frame", 24'h1, {23'h0, ctrl_o.power_down});
        wr(ADDR_LOOP2_PD, 8'h60);
        chk("loop2 off", 24'h3, {22'h0, ctrl_o.loop2_prescaler_off, ctrl_o.loop2_off});
        wr(ADDR_OPT1, 8'h9c);
        wr(ADDR_OPT2, 8'h37);
        chk("opt words", 24'h9c37, {8'h0, opt_word_o});
        wr(ADDR_CFG_LOCK_HI, 8'h12);
        wr(ADDR_CFG_LOCK_MID, 8'h34);
        wr(ADDR_CFG_LOCK_LO, 8'h56);
        chk("lock word", 24'h123456, cfg_lock_o);
        wr(ADDR_FIX_A, 8'h3c);
        rd_chk("pattern a rw", ADDR_FIX_A, 8'hff, 8'h3c);
        $display("t_writes done");
    endtask
    task automatic t_lock();
        logic [12:0] a;
        for (int n = 0; n < 2; n++) begin
            a = (n == 0) ? ADDR_LOCK1 : ADDR_LOCK2;
            set_lock(n, 1'b0);
            rd_chk("lock drop", a, 8'hff, 8'h04);
            set_lock(n, 1'b1);
            rd_chk("lock sticky", a, 8'hff, 8'h06);
            wr(a, 8'hfe);
            rd_chk("lock ro bits", a, 8'hff, 8'h06);
            wr(a, 8'h01);
            rd_chk("lock clear", a, 8'hff, 8'h02);
        end
        set_lock(0, 1'b0);
        set_lock(0, 1'b1);
        $display("t_lock done");
    endtask
    task automatic t_soft_reset();
        @(posedge mclk_i);
        sr_seen <= 1'b0;
        wr(ADDR_RESET_MODE, 8'h80);
        chk("reset pulse", 24'h1, {23'h0, sr_seen});
        chk("ctrl cleared", 24'h0, {19'h0, ctrl_o});
        chk("lock word default", 24'h0, cfg_lock_o);
        chk("opt default", 24'h0, {8'h0, opt_word_o});
        rd_chk("reset bit", ADDR_RESET_MODE, 8'hff, 8'h00);
        rd_chk("power default", ADDR_POWER_DOWN, 8'hff, 8'h00);
        rd_chk("pattern default", ADDR_FIX_A, 8'hff, 8'haa);
        rd_chk("flag cleared", ADDR_LOCK1, 8'hff, 8'h02);
        $display("t_soft_reset done");
    endtask
    task automatic t_wire_mode();
        wr(ADDR_RESET_MODE, 8'h10);
        chk("wire disable", 24'h1, {23'h0, ctrl_o.three_wire_disable});
        @(posedge mclk_i);
        four_wire <= 1'b1;
        readback_pin_sel_i <= 1'b1;
        oe_seen <= 1'b0;
        rd_chk("pin readback", ADDR_DEV_TYPE, 8'hff, DEV_T);
        rd_chk("mode readback", ADDR_RESET_MODE, 8'hff, 8'h10);
        chk("sdio quiet", 24'h0, {23'h0, oe_seen});
        readback_pin_sel_i <= 1'b0;
        rd_chk("pin unselected", ADDR_DEV_TYPE, 8'hff, 8'h00);
        wr(ADDR_RESET_MODE, 8'h00);
        four_wire <= 1'b0;
        rd_chk("three wire", ADDR_SI_REV, 8'hff, SREV);
        chk("sdio driven", 24'h1, {23'h0, oe_seen});
        $display("t_wire_mode done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        t_defaults();
        t_readonly();
        t_writes();
        t_lock();
        t_soft_reset();
        t_wire_mode();
        finish_test();
    end
    // watchdog well beyond the expected run of about 140 us
    initial begin
        #600000;
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end
endmodule // clock_chip_system_control_regs_tb
